// ---- rtl/nvsc_consts.svh ----
// timing and field constants for the nvsram store/recall host controller
`ifndef NVSC_CONSTS_SVH
`define NVSC_CONSTS_SVH

// ----------------------------------------------------------------
// clock and sram bus widths
// ----------------------------------------------------------------
`define NVSC_CLK_MHZ 125
`define NVSC_ADDR_W 15
`define NVSC_DATA_W 8

// ----------------------------------------------------------------
// bus cycle timing, in ns (45 ns grade, worst case)
// ----------------------------------------------------------------
`define NVSC_T_CYCLE_NS 45
`define NVSC_T_CYCLE_CYC ((`NVSC_T_CYCLE_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_T_HSB_NS 15
`define NVSC_T_HSB_CYC ((`NVSC_T_HSB_NS * `NVSC_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// nonvolatile operation times, in us
// ----------------------------------------------------------------
`define NVSC_T_SS_US 70
`define NVSC_T_RECALL_US 100
`define NVSC_T_DRAIN_US 70
`define NVSC_T_STORE_US 15000
`define NVSC_T_PURECALL_US 20000
`define NVSC_SS_CYC (`NVSC_T_SS_US * `NVSC_CLK_MHZ)
`define NVSC_RECALL_CYC ((`NVSC_T_SS_US + `NVSC_T_RECALL_US) * `NVSC_CLK_MHZ)
`define NVSC_STORE_CYC ((`NVSC_T_SS_US + `NVSC_T_STORE_US) * `NVSC_CLK_MHZ)
`define NVSC_HWSTORE_CYC ((`NVSC_T_DRAIN_US + `NVSC_T_STORE_US) * `NVSC_CLK_MHZ)
`define NVSC_PURECALL_CYC (`NVSC_T_PURECALL_US * `NVSC_CLK_MHZ)

`endif

// ---- rtl/nvsc_pkg.sv ----
// types for the nvsram store/recall host controller
`default_nettype none
package nvsc_pkg;
  // host request: op 0 read, 1 write, 2 soft store, 3 soft recall, 4 hw store
  typedef enum logic [2:0] {
    NVSC_OP_READ, NVSC_OP_WRITE, NVSC_OP_SSTORE, NVSC_OP_SRECALL, NVSC_OP_HSTORE
  } nvsc_op_t;

  typedef struct packed {
    nvsc_op_t op;
    logic [14:0] addr;
    logic [7:0] wdata;
  } nvsc_req_t;

  // soft command address sequence, six words each
  typedef logic [5:0][14:0] nvsc_seq_t;
endpackage : nvsc_pkg
`default_nettype wire

// ---- rtl/nvsc_host.sv ----
// host-side controller driving the nvsram pins and sequencing store/recall
// Functional notes
// - host holds write strobe high during every read cycle.
// - soft sequence advances only with select or output-enable timed reads.
// - soft command is six ordered reads with write strobe kept high.
// - host drives hardware store request low at least 15 ns.
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_consts.svh"

module nvsc_host #(
  parameter int unsigned SS_CYC = `NVSC_SS_CYC,
  parameter int unsigned RECALL_CYC = `NVSC_RECALL_CYC,
  parameter int unsigned STORE_CYC = `NVSC_STORE_CYC,
  parameter int unsigned HWSTORE_CYC = `NVSC_HWSTORE_CYC,
  parameter int unsigned PURECALL_CYC = `NVSC_PURECALL_CYC,
  parameter nvsc_pkg::nvsc_seq_t STORE_SEQ = '0,
  parameter nvsc_pkg::nvsc_seq_t RECALL_SEQ = '0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // user request side
  input wire logic req_valid_in,
  input wire nvsc_pkg::nvsc_req_t req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  // sram pins
  output logic [14:0] addr_out,
  output logic chip_sel_n_out,
  output logic out_en_n_out,
  output logic write_n_out,
  output logic [7:0] dq_out,
  output logic dq_oe_n_out,
  input wire logic [7:0] dq_in,
  // hardware store request, open drain
  output logic hw_store_request_n_out,
  output logic hw_store_request_n_oe_n_out,
  input wire logic hw_store_request_n_in
);
  import nvsc_pkg::*;

  localparam int unsigned CYC = `NVSC_T_CYCLE_CYC;
  localparam int unsigned HSB_CYC = `NVSC_T_HSB_CYC;

  typedef enum logic [2:0] {
    NVSC_ST_BOOT, NVSC_ST_IDLE, NVSC_ST_RD, NVSC_ST_WR, NVSC_ST_SEQ, NVSC_ST_HSB,
    NVSC_ST_WAIT
  } nvsc_state_t;

  nvsc_state_t state_q;
  logic [31:0] cnt_q;
  logic [2:0] idx_q;
  logic recall_q;
  nvsc_req_t cur_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic [14:0] addr_q;
  logic cs_n_q, oe_n_q, we_n_q, dq_oe_n_q, hsb_q;
  logic [7:0] dq_q;
  logic cyc_done;

  assign cyc_done = (cnt_q == 32'(CYC - 1));
  // accept only when idle; lockout covers boot recall and nv operations
  assign req_ready_out = (state_q == NVSC_ST_IDLE);
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_data_out = rsp_data_q;
  assign addr_out = addr_q;
  assign chip_sel_n_out = cs_n_q;
  assign out_en_n_out = oe_n_q;
  assign write_n_out = we_n_q;
  assign dq_out = dq_q;
  assign dq_oe_n_out = dq_oe_n_q;
  assign hw_store_request_n_out = 1'b0;
  assign hw_store_request_n_oe_n_out = ~hsb_q;

  // ----------------------------------------------------------------
  // sequencer: bus cycles and nonvolatile waits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= NVSC_ST_BOOT;
      cnt_q <= 32'h0000_0000;
      idx_q <= 3'h0;
      recall_q <= 1'b0;
      cur_q <= '0;
    end else begin
      case (state_q)
        // power-up recall window; no access before it ends
        NVSC_ST_BOOT: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(PURECALL_CYC - 1)) begin
            state_q <= NVSC_ST_IDLE;
            cnt_q <= 32'h0;
          end
        end
        NVSC_ST_IDLE: begin
          cnt_q <= 32'h0;
          idx_q <= 3'h0;
          if (req_valid_in) begin
            cur_q <= req_in;
            recall_q <= (req_in.op == NVSC_OP_SRECALL);
            case (req_in.op)
              NVSC_OP_READ: state_q <= NVSC_ST_RD;
              NVSC_OP_WRITE: state_q <= NVSC_ST_WR;
              NVSC_OP_HSTORE: state_q <= NVSC_ST_HSB;
              default: state_q <= NVSC_ST_SEQ;
            endcase
          end
        end
        NVSC_ST_RD, NVSC_ST_WR: begin
          cnt_q <= cyc_done ? 32'h0 : cnt_q + 32'h1;
          if (cyc_done) state_q <= NVSC_ST_IDLE;
        end
        // six back to back select-timed reads, never interrupted
        NVSC_ST_SEQ: begin
          cnt_q <= cyc_done ? 32'h0 : cnt_q + 32'h1;
          if (cyc_done) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h5) state_q <= NVSC_ST_WAIT;
          end
        end
        // hold request low for the pulse, then wait drain plus store
        NVSC_ST_HSB: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(HSB_CYC - 1)) begin
            state_q <= NVSC_ST_WAIT;
            cnt_q <= 32'h0;
          end
        end
        // worst-case wait; store may be skipped by the device but we wait anyway
        // a store pin still held low by someone else keeps the lockout going
        NVSC_ST_WAIT: begin
          cnt_q <= cnt_q + 32'h1;
          if (((cur_q.op == NVSC_OP_HSTORE && cnt_q >= 32'(HWSTORE_CYC - 1)) ||
               (cur_q.op == NVSC_OP_SSTORE && cnt_q >= 32'(STORE_CYC - 1)) ||
               (recall_q && cnt_q >= 32'(RECALL_CYC - 1))) && hw_store_request_n_in) begin
            state_q <= NVSC_ST_IDLE;
            cnt_q <= 32'h0;
          end
        end
        default: state_q <= NVSC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, all from flops
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q <= 15'h0000;
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_q <= 8'h00;
      dq_oe_n_q <= 1'b1;
      hsb_q <= 1'b0;
    end else begin
      // pull for all HSB_CYC cycles; one cycle less would undercut the pulse
      hsb_q <= (state_q == NVSC_ST_HSB);
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_oe_n_q <= 1'b1;
      if (state_q == NVSC_ST_IDLE && req_valid_in) begin
        addr_q <= req_in.addr;
        dq_q <= req_in.wdata;
        // write strobe is already high as select falls so the device never floats a read
        cs_n_q <= (req_in.op == NVSC_OP_HSTORE);
        oe_n_q <= (req_in.op == NVSC_OP_WRITE || req_in.op == NVSC_OP_HSTORE);
        we_n_q <= (req_in.op != NVSC_OP_WRITE);
        dq_oe_n_q <= (req_in.op != NVSC_OP_WRITE);
        if (req_in.op == NVSC_OP_SSTORE) addr_q <= STORE_SEQ[0];
        if (req_in.op == NVSC_OP_SRECALL) addr_q <= RECALL_SEQ[0];
      end else if ((state_q == NVSC_ST_RD || state_q == NVSC_ST_WR) && !cyc_done) begin
        cs_n_q <= 1'b0;
        oe_n_q <= (state_q == NVSC_ST_WR);
        we_n_q <= (state_q != NVSC_ST_WR) || (cnt_q == 32'(CYC - 2));
        dq_oe_n_q <= (state_q != NVSC_ST_WR);
      end else if (state_q == NVSC_ST_SEQ && !(cyc_done && idx_q == 3'h5)) begin
        // deselect one cycle between reads so each read clocks the sequence
        cs_n_q <= cyc_done;
        oe_n_q <= cyc_done;
        if (cyc_done) addr_q <= recall_q ? RECALL_SEQ[idx_q + 3'h1] : STORE_SEQ[idx_q + 3'h1];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rsp_valid_q <= (state_q == NVSC_ST_RD) && cyc_done;
      if (state_q == NVSC_ST_RD && cyc_done) rsp_data_q <= dq_in;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hsb_pulse_s;
    !hw_store_request_n_oe_n_out [*2];
  endsequence

  hsb_width_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(hw_store_request_n_oe_n_out) |-> hsb_pulse_s)
    else $error("store request pulse too short");

  read_we_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!chip_sel_n_out && !out_en_n_out) |-> write_n_out)
    else $error("write strobe low during read");

  we_not_early_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(chip_sel_n_out) && !out_en_n_out |-> write_n_out)
    else $error("write strobe low at select");

  lock_ready_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == NVSC_ST_WAIT) |-> !req_ready_out && chip_sel_n_out && write_n_out)
    else $error("access allowed during lockout");

  seq_we_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == NVSC_ST_SEQ) |-> write_n_out && dq_oe_n_out)
    else $error("write during soft sequence");

  seq_oe_timed_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == NVSC_ST_SEQ && !chip_sel_n_out) |-> !out_en_n_out)
    else $error("sequence read not output-enable timed");

  boot_lock_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == NVSC_ST_BOOT) |-> chip_sel_n_out)
    else $error("sram selected during power-up recall");

  wait_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == NVSC_ST_WAIT) |=> chip_sel_n_out)
    else $error("sram selected during nv operation");
endmodule : nvsc_host

`default_nettype wire

// ---- testbench/nvsc_dev_model.sv ----
// behavioural nvsram model facing the host controller pins
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model #(
  parameter nvsc_pkg::nvsc_seq_t STORE_SEQ = '0,
  parameter nvsc_pkg::nvsc_seq_t RECALL_SEQ = '0,
  parameter int BUSY_NS = 240
) (
  // sram pins
  input wire logic [14:0] addr_in,
  input wire logic chip_sel_n_in,
  input wire logic out_en_n_in,
  input wire logic write_n_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_drv_out,
  // store request pin level, pulled up
  input wire logic hwsr_n_in
);
  logic [7:0] mem [0:32767];
  logic [7:0] nv [0:32767];
  logic busy = 1'b0, dirty = 1'b0, wlow = 1'b0, wr_seen = 1'b0;
  logic [14:0] cyc_addr = '0;
  int sidx = 0, ridx = 0, n_store = 0, n_recall = 0, n_hw = 0;
  realtime fall_t = 0;
  // power-up recall, finished long before the host's boot wait ends
  initial begin
    foreach (nv[i]) nv[i] = 8'h00;
    mem = nv;
  end
  // array copy is instant; busy alone models the lockout window
  task automatic nv_op(input bit st);
    busy = 1'b1;
    if (st && dirty) begin
      nv = mem;
      n_store++;
    end
    if (!st) begin
      mem = nv;
      n_recall++;
    end
    dirty = 1'b0;
    busy <= #(BUSY_NS) 1'b0;
  endtask
  // supply drop stores, supply return recalls; sram contents lost between
  task automatic power_cycle;
    nv_op(1'b1);
    foreach (mem[i]) mem[i] = 8'hff;
    nv_op(1'b0);
  endtask
  // a miss restarts matching, counting the miss as word 0 if it fits
  task automatic adv(inout int idx, input nvsc_pkg::nvsc_seq_t s, input bit st);
    idx = (cyc_addr == s[idx]) ? idx + 1 : ((cyc_addr == s[0]) ? 1 : 0);
    if (idx == 6) begin
      idx = 0;
      nv_op(st);
    end
  endtask
  // strobe low at select keeps the outputs floating; address settles after
  always @(negedge chip_sel_n_in) begin
    wlow = !write_n_in;
    wr_seen = 1'b0;
    #1 cyc_addr = addr_in;
  end
  assign dq_drv_out = !chip_sel_n_in && !out_en_n_in && write_n_in && !wlow && !busy;
  assign dq_out = mem[addr_in];
  // write lands at the rising strobe and breaks any soft sequence
  always @(posedge write_n_in) if (!chip_sel_n_in && !busy) begin
    mem[addr_in] = dq_in;
    dirty = 1'b1;
    wr_seen = 1'b1;
    sidx = 0;
    ridx = 0;
  end
  // soft sequence steps only on select-timed reads
  always @(posedge chip_sel_n_in) if (!wr_seen && !busy) begin
    adv(sidx, STORE_SEQ, 1'b1);
    adv(ridx, RECALL_SEQ, 1'b0);
  end
  // store pin: a low pulse of 15 ns or more requests a store
  always @(negedge hwsr_n_in) fall_t = $realtime;
  always @(posedge hwsr_n_in) if ($realtime - fall_t >= 15.0) begin
    n_hw++;
    nv_op(1'b1);
  end
endmodule : nvsc_dev_model
`default_nettype wire

// ---- testbench/nvsc_host_tb.sv ----
// self-checking bench for the nvsram store/recall host controller
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_tb;
  import nvsc_pkg::*;
  localparam int unsigned PC = 50;
  localparam int unsigned CYC = 50;
  // palindromic sequences so word order inside the vector cannot matter
  localparam nvsc_seq_t SSEQ = {15'h0e38, 15'h31c7, 15'h03e0, 15'h03e0, 15'h31c7, 15'h0e38};
  localparam nvsc_seq_t RSEQ = {15'h0c63, 15'h3b5c, 15'h0fc0, 15'h0fc0, 15'h3b5c, 15'h0c63};
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
  nvsc_req_t req_in = '0;
  logic req_ready_out, rsp_valid_out, chip_sel_n_out, out_en_n_out, write_n_out;
  logic dq_oe_n_out, hwsr_out, hwsr_oe_n_out, dev_drv, hwsr_lvl;
  logic [7:0] rsp_data_out, dq_out, dev_dq, dq_w, last_dq = 8'h00;
  logic [14:0] addr_out;
  int mismatches = 0, cmp_count = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  // released data lines show the inverse of the last value; pin pulled up
  assign dq_w = !dq_oe_n_out ? dq_out : (dev_drv ? dev_dq : ~last_dq);
  assign hwsr_lvl = hwsr_oe_n_out ? 1'b1 : hwsr_out;
  always @(posedge ref_clk_in) if (!dq_oe_n_out || dev_drv) last_dq <= dq_w;
  nvsc_host #(.SS_CYC(CYC), .RECALL_CYC(CYC), .STORE_CYC(CYC), .HWSTORE_CYC(CYC),
    .PURECALL_CYC(PC), .STORE_SEQ(SSEQ), .RECALL_SEQ(RSEQ)) i_nvsc_host (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .addr_out(addr_out), .chip_sel_n_out(chip_sel_n_out),
    .out_en_n_out(out_en_n_out), .write_n_out(write_n_out), .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out), .dq_in(dq_w), .hw_store_request_n_out(hwsr_out),
    .hw_store_request_n_oe_n_out(hwsr_oe_n_out), .hw_store_request_n_in(hwsr_lvl));
  nvsc_dev_model #(.STORE_SEQ(SSEQ), .RECALL_SEQ(RSEQ), .BUSY_NS(240)) i_nvsc_dev_model (
    .addr_in(addr_out), .chip_sel_n_in(chip_sel_n_out), .out_en_n_in(out_en_n_out),
    .write_n_in(write_n_out), .dq_in(dq_w), .dq_out(dev_dq), .dq_drv_out(dev_drv),
    .hwsr_n_in(hwsr_lvl));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // bounded wait so a stuck controller is reported, not hung on
  task automatic wait_rdy(output int n);
    n = 0;
    while (req_ready_out !== 1'b1 && n < 1000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk(16'(n < 1000), 16'h1);
  endtask : wait_rdy
  task automatic req(input nvsc_op_t op, input logic [14:0] a, input logic [7:0] d);
    int n;
    wait_rdy(n);
    req_valid_in = 1'b1;
    req_in = '{op, a, d};
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
  endtask : req
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    int n;
    req(NVSC_OP_READ, a, 8'h00);
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 12) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk(16'(n), 16'h6);
    chk({8'h00, rsp_data_out}, {8'h00, exp});
  endtask : rd
  // host-side pin monitors: strobe high in reads, idle during nv work
  always @(negedge ref_clk_in) if (rst_n_in) begin
    if (out_en_n_out === 1'b0) chk(16'(write_n_out), 16'h1);
    if (i_nvsc_dev_model.busy) chk(16'(chip_sel_n_out), 16'h1);
  end
  task automatic t_boot;
    int n;
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    wait_rdy(n);
    chk(16'(n >= PC), 16'h1);
  endtask : t_boot
  task automatic t_rw;
    req(NVSC_OP_WRITE, 15'h0000, 8'h3c);
    req(NVSC_OP_WRITE, 15'h7fff, 8'hc3);
    rd(15'h7fff, 8'hc3);
    rd(15'h0000, 8'h3c);
  endtask : t_rw
  task automatic t_soft;
    int n;
    req(NVSC_OP_WRITE, 15'h0123, 8'h5a);
    req(NVSC_OP_SSTORE, 15'h0000, 8'h00);
    wait_rdy(n);
    chk(16'(i_nvsc_dev_model.n_store), 16'h1);
    req(NVSC_OP_SSTORE, 15'h0000, 8'h00);
    wait_rdy(n);
    chk(16'(i_nvsc_dev_model.n_store), 16'h1);
    req(NVSC_OP_WRITE, 15'h0123, 8'ha5);
    req(NVSC_OP_SRECALL, 15'h0000, 8'h00);
    wait_rdy(n);
    chk(16'(i_nvsc_dev_model.n_recall), 16'h1);
    rd(15'h0123, 8'h5a);
  endtask : t_soft
  task automatic t_hw;
    int n;
    req(NVSC_OP_WRITE, 15'h4321, 8'h77);
    req(NVSC_OP_HSTORE, 15'h0000, 8'h00);
    wait_rdy(n);
    chk(16'(i_nvsc_dev_model.n_hw), 16'h1);
    req(NVSC_OP_WRITE, 15'h4321, 8'h00);
    req(NVSC_OP_SRECALL, 15'h0000, 8'h00);
    rd(15'h4321, 8'h77);
  endtask : t_hw
  // power loss in mid-run: host reset again, device stores then recalls
  task automatic t_pwr;
    int n;
    req(NVSC_OP_WRITE, 15'h2222, 8'h99);
    wait_rdy(n);
    rst_n_in = 1'b0;
    i_nvsc_dev_model.power_cycle();
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    wait_rdy(n);
    chk(16'(n >= PC), 16'h1);
    chk(16'(i_nvsc_dev_model.n_store), 16'h3);
    rd(15'h2222, 8'h99);
  endtask : t_pwr
  initial begin
    t_boot();
    t_rw();
    t_soft();
    t_hw();
    t_pwr();
    end_sim();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule : nvsc_host_tb
`default_nettype wire
